// ===== logic/ras_regs.svh
`ifndef RAS_REGS_SVH
`define RAS_REGS_SVH

// Function codes of inputs and outputs
`define RAS_INCODE_INV1_FAULT 8'h8c
`define RAS_INCODE_INV2_FAULT 8'h8d
`define RAS_OUTCODE_INV1_RUN 8'h02
`define RAS_OUTCODE_INV2_RUN 8'h04
`define RAS_ANCODE_INV1_A 8'h03
`define RAS_ANCODE_INV1_B 8'h0c
`define RAS_ANCODE_INV2_A 8'h05
`define RAS_ANCODE_INV2_B 8'h0e

// Level thresholds in percent
`define RAS_LEVEL_LOW_PCT 7'h0f
`define RAS_LEVEL_HIGH_PCT 7'h59

// Analog minimum code: 0 V or 4 mA
`define RAS_AO_MIN 12'h000

// Timing: 1 s tick at 250 MHz, 45 min and 1 min persistence
`define RAS_CLK_HZ 250000000
`define RAS_TICK_CYCLES 250000000
`define RAS_LEVEL_SECONDS 2700
`define RAS_OIL_SECONDS 60

// Register map on the Avalon-MM slave (word addresses)
`define RAS_REG_STATUS 4'h0
`define RAS_REG_CONTROL 4'h1
`define RAS_REG_HOURS1 4'h2
`define RAS_REG_HOURS2 4'h3
`define RAS_REG_LIMIT 4'h4
`define RAS_REG_DICODE 4'h5
`define RAS_REG_LEVEL 4'h6

// Status bit positions
`define RAS_ST_SVC1 0
`define RAS_ST_SVC2 1
`define RAS_ST_FLT1 2
`define RAS_ST_FLT2 3
`define RAS_ST_LEVEL 4
`define RAS_ST_DISC 5
`define RAS_ST_OIL 6

// Control bit positions (write one: action pulse)
`define RAS_CT_RST_HRS1 0
`define RAS_CT_RST_HRS2 1
`define RAS_CT_CLR_DISC 2

`define RAS_LIMIT_RESET 32'h00002710
`define RAS_DICODE_RESET 16'h8d8c

`endif

// ===== logic/ras_pkg.sv
`default_nettype none
package ras_pkg;
   // Avalon-MM request bundle
   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } ras_bus_req_t;

   // Registered alarm flags, in status bit order
   typedef struct packed {
      logic oil;
      logic disc;
      logic level;
      logic flt2;
      logic flt1;
      logic svc2;
      logic svc1;
   } ras_alarm_t;

   typedef enum logic [1:0] {
      RAS_IDLE = 2'b00,
      RAS_ACK = 2'b01
   } ras_bus_st_t;
endpackage
`default_nettype wire

// ===== logic/ras_persist.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// Persistence timer
// --------------------------------------------------
module ras_persist #(
   parameter int unsigned SECONDS = 60
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic cond,
   output logic held
);
   logic [31:0] cnt_q;

   // Counts ticks while cond holds, restarts when cond drops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 32'h0;
      end else if (!cond) begin
         cnt_q <= 32'h0; // R12
      end else if (tick && cnt_q < SECONDS) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   assign held = cond && (cnt_q >= SECONDS);
endmodule
`default_nettype wire

// ===== logic/ras_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ras_regs.svh"
// Overview of operation
// R1: Service alarm when hours reach limit
// R2: Service alarm signals only, cleared by hour reset
// R3: Inputs coded 140/141 are inverter faults
// R4: Fault switches off run outputs 2/4
// R5: Fault forces analog outputs to minimum
// R6: Fault clears itself when input drops
// R7: Low level 45 min warns; clears 15-89% (code clears only strictly inside, 16-88%)
// R8: Rupture-disc closure warns via buzzer, relay
// R9: Rupture-disc warning latched until manual clear
// R10: Oil separator closure over 1 min warns
// R11: Oil warning clears when input false
// R12: Timers from prescaled tick, restart on false
module ras_supervisor
   import ras_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `RAS_TICK_CYCLES,
   parameter int unsigned DI_COUNT = 8
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [DI_COUNT-1:0] DI_PIN,
   input wire logic INV1_RUNNING,
   input wire logic INV2_RUNNING,
   input wire logic REC_DISC_PIN,
   input wire logic OIL_SEP_PIN,
   input wire logic [6:0] LEVEL_PCT,
   input wire logic INV1_RUN_REQ,
   input wire logic INV2_RUN_REQ,
   input wire logic [11:0] INV1_AO_REQ,
   input wire logic [11:0] INV2_AO_REQ,
   output logic INV1_RUN,
   output logic INV2_RUN,
   output logic [11:0] INV1_AO,
   output logic [11:0] INV2_AO,
   output logic BUZZER,
   output logic ALARM_RELAY,
   output logic [6:0] ALARM_STATUS
);
   // --------------------------------------------------
   // Pin synchronisers (three stages, second and third agree)
   // --------------------------------------------------
   localparam int SW = DI_COUNT + 4;
   logic [SW-1:0] s1_q, s2_q, s3_q, pin_q;
   logic [SW-1:0] pins;
   assign pins = {OIL_SEP_PIN, REC_DISC_PIN, INV2_RUNNING, INV1_RUNNING,
                  DI_PIN};

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Filtered pin value changes only when stages two and three agree
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         pin_q <= '0;
      end else begin
         for (int i = 0; i < SW; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               pin_q[i] <= s3_q[i];
            end
         end
      end
   end

   logic [DI_COUNT-1:0] di;
   logic run1, run2, disc_in, oil_in;
   assign di = pin_q[DI_COUNT-1:0];
   assign run1 = pin_q[DI_COUNT];
   assign run2 = pin_q[DI_COUNT+1];
   assign disc_in = pin_q[DI_COUNT+2];
   assign oil_in = pin_q[DI_COUNT+3];

   // Level input arrives as a sampled bus, three stages
   logic [6:0] lv1_q, lv2_q, lv3_q, level_q;
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         lv1_q <= `RAS_LEVEL_LOW_PCT;
         lv2_q <= `RAS_LEVEL_LOW_PCT;
         lv3_q <= `RAS_LEVEL_LOW_PCT;
         level_q <= `RAS_LEVEL_LOW_PCT;
      end else begin
         lv1_q <= LEVEL_PCT;
         lv2_q <= lv1_q;
         lv3_q <= lv2_q;
         if (lv2_q == lv3_q) begin
            level_q <= lv3_q;
         end
      end
   end

   // --------------------------------------------------
   // Registers and bus slave
   // --------------------------------------------------
   ras_bus_req_t req;
   ras_bus_st_t bus_q;
   logic [31:0] limit_q, hours1_q, hours2_q, rdata_q;
   logic [15:0] dicode_q;
   logic [6:0] alarm_q;
   logic acc, wr_acc;
   logic [31:0] rd_mux;
   assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                  writedata: AVS_WRITEDATA};
   assign acc = (bus_q == RAS_IDLE) && (req.read || req.write);
   assign wr_acc = (bus_q == RAS_ACK) && req.write; // Commit at answer edge

   // One wait cycle, then answer with waitrequest low
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         bus_q <= RAS_IDLE;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         case (bus_q)
            RAS_IDLE: begin
               if (req.read || req.write) begin
                  bus_q <= RAS_ACK;
                  AVS_WAITREQUEST <= 1'b0;
               end
            end
            RAS_ACK: begin
               bus_q <= RAS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
            default: begin
               bus_q <= RAS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   // Read multiplexer, unmapped reads as zero
   always_comb begin
      case (req.address)
         `RAS_REG_STATUS: rd_mux = {25'h0, alarm_q};
         `RAS_REG_HOURS1: rd_mux = hours1_q;
         `RAS_REG_HOURS2: rd_mux = hours2_q;
         `RAS_REG_LIMIT: rd_mux = limit_q;
         `RAS_REG_DICODE: rd_mux = {16'h0, dicode_q};
         `RAS_REG_LEVEL: rd_mux = {25'h0, level_q};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         AVS_READDATA <= 32'h0;
      end else if (acc && req.read) begin
         AVS_READDATA <= rd_mux;
      end
   end

   // Configuration registers
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         limit_q <= `RAS_LIMIT_RESET;
         dicode_q <= `RAS_DICODE_RESET;
      end else if (wr_acc) begin
         if (req.address == `RAS_REG_LIMIT) begin
            limit_q <= req.writedata;
         end
         if (req.address == `RAS_REG_DICODE) begin
            dicode_q <= req.writedata[15:0];
         end
      end
   end

   logic ctl_wr, rst_h1, rst_h2, clr_disc;
   assign ctl_wr = wr_acc && (req.address == `RAS_REG_CONTROL);
   assign rst_h1 = ctl_wr && req.writedata[`RAS_CT_RST_HRS1];
   assign rst_h2 = ctl_wr && req.writedata[`RAS_CT_RST_HRS2];
   assign clr_disc = ctl_wr && req.writedata[`RAS_CT_CLR_DISC];

   // --------------------------------------------------
   // Prescaled one-second tick
   // --------------------------------------------------
   logic [31:0] pre_q;
   logic tick_q;
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         pre_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (pre_q >= TICK_CYCLES - 1) begin
         pre_q <= 32'h0; // R12
         tick_q <= 1'b1;
      end else begin
         pre_q <= pre_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // Running-time accumulators in seconds of inverter run
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         hours1_q <= 32'h0;
         hours2_q <= 32'h0;
      end else begin
         if (rst_h1) begin
            hours1_q <= 32'h0;
         end else if (tick_q && run1 && hours1_q != 32'hffffffff) begin
            hours1_q <= hours1_q + 32'h1;
         end
         if (rst_h2) begin
            hours2_q <= 32'h0;
         end else if (tick_q && run2 && hours2_q != 32'hffffffff) begin
            hours2_q <= hours2_q + 32'h1;
         end
      end
   end

   // --------------------------------------------------
   // Alarm detection
   // --------------------------------------------------
   // When the fault's code byte matches, any active input asserts that fault
   function automatic logic code_hit(input logic [DI_COUNT-1:0] d,
                                     input logic [7:0] code,
                                     input logic [7:0] want);
      logic hit;
      hit = 1'b0;
      if (code == want) begin
         hit = |d;
      end
      return hit;
   endfunction

   logic flt1, flt2, level_low, level_ok, level_held, oil_held;
   assign flt1 = code_hit(di[DI_COUNT-1:0], dicode_q[7:0],
                          `RAS_INCODE_INV1_FAULT); // R3
   assign flt2 = code_hit(di[DI_COUNT-1:0], dicode_q[15:8],
                          `RAS_INCODE_INV2_FAULT); // R3
   assign level_low = level_q < `RAS_LEVEL_LOW_PCT;
   assign level_ok = (level_q > `RAS_LEVEL_LOW_PCT) &&
                     (level_q < `RAS_LEVEL_HIGH_PCT);

   ras_persist #(.SECONDS(`RAS_LEVEL_SECONDS)) u_level_timer (
      .clk(SYS_CLK),
      .rst(RESET),
      .tick(tick_q),
      .cond(level_low),
      .held(level_held)
   );

   ras_persist #(.SECONDS(`RAS_OIL_SECONDS + 1)) u_oil_timer (
      .clk(SYS_CLK),
      .rst(RESET),
      .tick(tick_q),
      .cond(oil_in),
      .held(oil_held)
   );

   // Alarm flags: set wins over clear, except an hour reset clears its service flag
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         alarm_q <= 7'h00;
      end else begin
         alarm_q[`RAS_ST_SVC1] <= (hours1_q >= limit_q) && !rst_h1; // R1 R2
         alarm_q[`RAS_ST_SVC2] <= (hours2_q >= limit_q) && !rst_h2; // R1 R2
         alarm_q[`RAS_ST_FLT1] <= flt1; // R6
         alarm_q[`RAS_ST_FLT2] <= flt2; // R6
         if (level_held) begin
            alarm_q[`RAS_ST_LEVEL] <= 1'b1; // R7
         end else if (level_ok) begin
            alarm_q[`RAS_ST_LEVEL] <= 1'b0; // R7
         end
         if (disc_in) begin
            alarm_q[`RAS_ST_DISC] <= 1'b1; // R8 R9
         end else if (clr_disc) begin
            alarm_q[`RAS_ST_DISC] <= 1'b0; // R9
         end
         alarm_q[`RAS_ST_OIL] <= oil_held; // R10 R11
      end
   end

   // --------------------------------------------------
   // Outputs
   // --------------------------------------------------
   // Faults override inverter run and analog demand
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         INV1_RUN <= 1'b0;
         INV2_RUN <= 1'b0;
         INV1_AO <= `RAS_AO_MIN;
         INV2_AO <= `RAS_AO_MIN;
      end else begin
         INV1_RUN <= INV1_RUN_REQ && !flt1; // R4
         INV2_RUN <= INV2_RUN_REQ && !flt2; // R4
         INV1_AO <= flt1 ? `RAS_AO_MIN : INV1_AO_REQ; // R5
         INV2_AO <= flt2 ? `RAS_AO_MIN : INV2_AO_REQ; // R5
      end
   end

   // Warnings drive buzzer and relay; service alarm does not
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         BUZZER <= 1'b0;
         ALARM_RELAY <= 1'b0;
         ALARM_STATUS <= 7'h00;
      end else begin
         BUZZER <= alarm_q[`RAS_ST_LEVEL] | alarm_q[`RAS_ST_DISC] |
                   alarm_q[`RAS_ST_OIL]; // R7 R8 R10
         ALARM_RELAY <= alarm_q[`RAS_ST_LEVEL] | alarm_q[`RAS_ST_DISC] |
                        alarm_q[`RAS_ST_OIL]; // R7 R8 R10
         ALARM_STATUS <= alarm_q; // R2
      end
   end
endmodule
`default_nettype wire

// ===== verif/ras_sup_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Supervisor port checker
// ----
module ras_sup_props #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic OIL_SEP_PIN,
   input wire logic [6:0] LEVEL_PCT,
   input wire logic INV1_RUN_REQ,
   input wire logic INV1_RUN,
   input wire logic [11:0] INV1_AO,
   input wire logic [11:0] INV2_AO,
   input wire logic BUZZER,
   input wire logic ALARM_RELAY,
   input wire logic [6:0] ALARM_STATUS
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   int unsigned oil_q;
   int unsigned lvl_q;
   logic [1:0] up_q;
   wire logic clr = AVS_WRITE && AVS_ADDRESS == 4'h1 && AVS_WRITEDATA[2];
   // Cycles each persistence condition has held, cycles since reset
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         oil_q <= 0;
         lvl_q <= 0;
         up_q <= 2'h0;
      end else begin
         if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
         end
         oil_q <= OIL_SEP_PIN ? oil_q + 1 : 0;
         lvl_q <= (LEVEL_PCT < 7'h0f) ? lvl_q + 1 : 0;
      end
   end
   // Output relations
   // Run and analog outputs lead the status flags by one cycle
   run_gate_a: assert property (
      ALARM_STATUS[2] |-> !$past(INV1_RUN))
      else $error("run output on during fault");
   ao1_min_a: assert property (
      ALARM_STATUS[2] |-> $past(INV1_AO) == 12'h000)
      else $error("analog 1 not at minimum");
   ao2_min_a: assert property (
      ALARM_STATUS[3] |-> $past(INV2_AO) == 12'h000)
      else $error("analog 2 not at minimum");
   run_back_a: assert property (
      up_q == 2'h3 && !ALARM_STATUS[2] |->
      $past(INV1_RUN) == $past(INV1_RUN_REQ, 2))
      else $error("run output not restored");
   relay_same_a: assert property (BUZZER == ALARM_RELAY)
      else $error("buzzer and relay differ");
   warn_out_a: assert property ((|ALARM_STATUS[6:4]) [*2] |-> BUZZER)
      else $error("warning without buzzer");
   disc_latch_a: assert property (
      ALARM_STATUS[5] && !clr && !$past(clr) && !$past(clr, 2) |=>
      ALARM_STATUS[5])
      else $error("disc warning dropped");
   oil_clear_a: assert property (
      (!OIL_SEP_PIN) [*8] |-> !ALARM_STATUS[6])
      else $error("oil warning stuck");
   oil_hold_a: assert property (
      $rose(ALARM_STATUS[6]) |-> oil_q >= 60 * TICK_CYCLES)
      else $error("oil warning too early");
   level_hold_a: assert property (
      $rose(ALARM_STATUS[4]) |-> lvl_q >= 2699 * TICK_CYCLES)
      else $error("level warning too early");
   cover property ($rose(ALARM_STATUS[6]));
   cover property ($rose(ALARM_STATUS[5]));
   cover property ($rose(ALARM_STATUS[3]));
endmodule
`default_nettype wire

// ===== verif/ras_field.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Field contacts and level sensor
// ----
module ras_field (
   input wire logic clk,
   input wire logic [7:0] di_set,
   input wire logic r1_set,
   input wire logic r2_set,
   input wire logic disc_set,
   input wire logic oil_set,
   input wire logic [6:0] lvl_set,
   output logic [7:0] di = 8'h00,
   output logic r1 = 1'b0,
   output logic r2 = 1'b0,
   output logic disc = 1'b0,
   output logic oil = 1'b0,
   output logic [6:0] lvl = 7'h32
);
   // Contacts settle one cycle after each command
   always @(posedge clk) begin
      di <= di_set;
      r1 <= r1_set;
      r2 <= r2_set;
      disc <= disc_set;
      oil <= oil_set;
      lvl <= lvl_set;
   end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q;
   logic [7:0] di_s = 8'h00;
   logic r1_s = 1'b0;
   logic r2_s = 1'b0;
   logic dc_s = 1'b0;
   logic oil_s = 1'b0;
   logic [6:0] lv_s = 7'h32;
   logic [11:0] a1 = 12'h5a5;
   logic [11:0] a2 = 12'h3c3;
   logic [1:0] rq = 2'b11;
   wire logic [31:0] rdat;
   wire logic wreq, r1, r2, dc, oil, run1, run2, buz, rly;
   wire logic [7:0] di;
   wire logic [6:0] lv, st;
   wire logic [11:0] ao1, ao2;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   ras_field u_field (.clk(clk), .di_set(di_s), .r1_set(r1_s), .r2_set(r2_s),
      .disc_set(dc_s), .oil_set(oil_s), .lvl_set(lv_s), .di(di), .r1(r1),
      .r2(r2), .disc(dc), .oil(oil), .lvl(lv));
   ras_supervisor #(.TICK_CYCLES(4), .DI_COUNT(8)) uut (.SYS_CLK(clk),
      .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
      .DI_PIN(di), .INV1_RUNNING(r1), .INV2_RUNNING(r2), .REC_DISC_PIN(dc),
      .OIL_SEP_PIN(oil), .LEVEL_PCT(lv), .INV1_RUN_REQ(rq[0]),
      .INV2_RUN_REQ(rq[1]), .INV1_AO_REQ(a1), .INV2_AO_REQ(a2),
      .INV1_RUN(run1), .INV2_RUN(run2), .INV1_AO(ao1), .INV2_AO(ao2),
      .BUZZER(buz), .ALARM_RELAY(rly), .ALARM_STATUS(st));
   task automatic close_out();
      if (n_fail == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Avalon-MM transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      rd <= !w;
      wr <= w;
      wd <= d;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic sts(input logic [8:0] e);
      chk({23'h0, buz, rly, st}, {23'h0, e});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Main sequence
   initial begin
      wt(5);
      rst <= 1'b0;
      rchk(4'h4, 32'h00002710);
      rchk(4'h5, 32'h00008d8c);
      rchk(4'h6, 32'h00000032);
      bus(1'b1, 4'h0, 32'h7f);
      bus(1'b1, 4'h9, 32'h1234);
      rchk(4'h0, 32'h0);
      rchk(4'h9, 32'h0);
      rq <= 2'b10;
      wt(3);
      chk({30'h0, run1, run2}, 32'h1);
      rq <= 2'b11;
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, 4'h5, k ? 32'h8d00 : 32'h008c);
         di_s <= 8'h10 << k;
         wt(10);
         sts(9'h004 << k);
         chk({6'h0, run1, run2, ao1, ao2}, {6'h0, k == 1, k == 0,
            k ? a1 : 12'h000, k ? 12'h000 : a2});
         di_s <= 8'h00;
         wt(10);
         sts(9'h000);
         chk({6'h0, run1, run2, ao1, ao2}, {6'h0, 2'b11, a1, a2});
      end
      bus(1'b1, 4'h5, 32'h00008d8c);
      bus(1'b1, 4'h4, 32'h3);
      rchk(4'h4, 32'h3);
      for (int k = 0; k < 2; k++) begin
         r1_s <= (k == 0);
         r2_s <= (k == 1);
         wt(6);
         sts(9'h000);
         wt(30);
         r1_s <= 1'b0;
         r2_s <= 1'b0;
         wt(40);
         sts(9'h001 << k);
         chk({30'h0, run1, run2}, 32'h3);
         bus(1'b1, 4'h1, 32'h1 << k);
         wt(10);
         sts(9'h000);
         rchk(k ? 4'h3 : 4'h2, 32'h0);
      end
      dc_s <= 1'b1;
      wt(10);
      dc_s <= 1'b0;
      wt(60);
      sts(9'h1a0);
      rchk(4'h0, 32'h20);
      bus(1'b1, 4'h1, 32'h4);
      wt(10);
      sts(9'h000);
      oil_s <= 1'b1;
      wt(200);
      oil_s <= 1'b0;
      wt(4);
      oil_s <= 1'b1;
      wt(200);
      sts(9'h000);
      wt(60);
      sts(9'h1c0);
      oil_s <= 1'b0;
      wt(10);
      sts(9'h000);
      lv_s <= 7'h0a;
      wt(10700);
      sts(9'h000);
      wt(140);
      sts(9'h190);
      lv_s <= 7'h59;
      wt(20);
      sts(9'h190);
      lv_s <= 7'h0f;
      wt(20);
      sts(9'h190);
      lv_s <= 7'h32;
      wt(20);
      sts(9'h000);
      close_out();
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
endmodule
bind ras_supervisor ras_sup_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .SYS_CLK(SYS_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .OIL_SEP_PIN(OIL_SEP_PIN), .LEVEL_PCT(LEVEL_PCT),
   .INV1_RUN_REQ(INV1_RUN_REQ), .INV1_RUN(INV1_RUN), .INV1_AO(INV1_AO),
   .INV2_AO(INV2_AO), .BUZZER(BUZZER), .ALARM_RELAY(ALARM_RELAY),
   .ALARM_STATUS(ALARM_STATUS));
`default_nettype wire
